// ===== include/bridge_window_defs.vh
// Offsets, field positions and reset values of the bridge window and status registers
`ifndef BRIDGE_WINDOW_DEFS_VH
`define BRIDGE_WINDOW_DEFS_VH

// Register word offsets (byte addresses)
`define OFS_IO_STATUS      8'h1c
`define OFS_MEM_WINDOW     8'h20
`define OFS_IO_UPPER       8'h30
`define OFS_IRQ_MASK       8'h40
`define OFS_CONTROL        8'h44

// Fixed I/O addressing indicator nibble
`define IO_32BIT_IND       4'h1

// Field positions in word 0x1c
`define IO_BOT_LSB         4
`define IO_TOP_LSB         12
`define IO_IND_BOT_LSB     0
`define IO_IND_TOP_LSB     8

// Memory word field positions
`define MEM_BOT_LSB        4
`define MEM_TOP_LSB        20

// Control register bits
`define CTL_PERR_EN_BIT    0
`define CTL_SERR_EN_BIT    1

// Sticky flag indices (status bit = index + 24)
`define FLAG_PARITY        0
`define FLAG_SIG_ABORT     3
`define FLAG_RCV_ABORT     4
`define FLAG_RCV_UNSUP     5
`define FLAG_SYS_ERR       6
`define FLAG_POISON        7
`define FLAG_COUNT         8
`define FLAG_LSB           24

// Reset values
`define RST_IO_FIELD       4'h0
`define RST_MEM_FIELD      12'h000
`define RST_IO_UPPER       16'h0000
`define RST_FLAGS          8'h00
`define RST_MASK           8'h00

`endif

// ===== src/window_compare.v
// Address window compare: inclusive bottom and top bounds
`timescale 1ns/1ns
`default_nettype none

module window_compare (
    // Bounds and address
    input  wire [31:0] bottom,
    input  wire [31:0] top,
    input  wire [31:0] addr,
    // Result
    output wire        hit
);

    assign hit = (addr >= bottom) && (addr <= top);

endmodule // window_compare

`default_nettype wire

// ===== src/bridge_window_regs.v
// Bridge I/O and memory window registers, secondary status flags, decode
// What this block does
// - I/O indicator nibbles always read one
// - I/O base bits 7:4 give bottom 15:12
// - I/O limit bits 15:12 give top 15:12
// - Upper sixteen I/O address bits from registers
// - I/O forwarding decided by window bounds
// - Legacy secondary status bits hardwired zero
// - Parity error sets bit 24, write-one-clears
// - Bit 24 never set without parity enable
// - Completer abort sent sets bit 27
// - Completer abort received sets bit 28
// - Unsupported request received sets bit 29
// - Error message with SERR enable sets 30
// - Poisoned TLP received sets bit 31
// - Memory base bits 15:4 give bottom
// - Memory forwarding decided by window bounds
// - Memory limit 31:20 gives top, ones below
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ns
`default_nettype none
`include "bridge_window_defs.vh"

module bridge_window_regs (
    // Clock and reset
    input  wire        clk,
    input  wire        reset_n,
    // Register port
    input  wire [7:0]  reg_addr,
    input  wire [31:0] reg_wdata,
    input  wire        reg_write,
    input  wire        reg_read,
    output reg  [31:0] reg_rdata,
    // Secondary-side events, one-cycle pulses
    input  wire        ev_parity_error,
    input  wire        ev_completer_abort_sent,
    input  wire        ev_completer_abort_rcvd,
    input  wire        ev_unsupported_rcvd,
    input  wire        ev_error_msg_sent,
    input  wire        ev_poisoned_rcvd,
    // Transaction to decode
    input  wire        txn_valid,
    input  wire        txn_is_io,
    input  wire [31:0] txn_addr,
    output reg         txn_fwd_valid,
    output reg         txn_forward,
    // Interrupt
    output reg         irq
);

    reg  [3:0]  io_bot_q;
    reg  [3:0]  io_top_q;
    reg  [15:0] io_bot_up_q;
    reg  [15:0] io_top_up_q;
    reg  [11:0] mem_bot_q;
    reg  [11:0] mem_top_q;
    reg  [7:0]  flags_q;
    reg  [7:0]  flags_d;
    reg  [7:0]  mask_q;
    reg         perr_en_q;
    reg         serr_en_q;
    reg  [7:0]  ev_vec;
    reg  [7:0]  wclr;
    reg  [31:0] rdata_d;

    wire [31:0] io_bottom;
    wire [31:0] io_top;
    wire [31:0] mem_bottom;
    wire [31:0] mem_top;
    wire        io_hit;
    wire        mem_hit;
    wire        wr_status;

    assign wr_status = reg_write && (reg_addr == `OFS_IO_STATUS);

    // Expanded window bounds
    assign io_bottom  = {io_bot_up_q, io_bot_q, 12'h000};
    assign io_top     = {io_top_up_q, io_top_q, 12'hfff};
    assign mem_bottom = {mem_bot_q, 20'h00000};
    assign mem_top    = {mem_top_q, 20'hfffff};

    window_compare u_io_cmp (
        .bottom (io_bottom),
        .top    (io_top),
        .addr   (txn_addr),
        .hit    (io_hit)
    );

    window_compare u_mem_cmp (
        .bottom (mem_bottom),
        .top    (mem_top),
        .addr   (txn_addr),
        .hit    (mem_hit)
    );

    // Event vector, gated by the enables
    always @* begin
        ev_vec = 8'h00;
        ev_vec[`FLAG_PARITY]    = ev_parity_error && perr_en_q;
        ev_vec[`FLAG_SIG_ABORT] = ev_completer_abort_sent;
        ev_vec[`FLAG_RCV_ABORT] = ev_completer_abort_rcvd;
        ev_vec[`FLAG_RCV_UNSUP] = ev_unsupported_rcvd;
        ev_vec[`FLAG_SYS_ERR]   = ev_error_msg_sent && serr_en_q;
        ev_vec[`FLAG_POISON]    = ev_poisoned_rcvd;
    end

    // Write-one-clear; the read-only abort and unsupported-request flags ignore software writes
    always @* begin
        wclr = 8'h00;
        if (wr_status) begin
            wclr = reg_wdata[`FLAG_LSB +: 8];
        end
        wclr[`FLAG_SIG_ABORT] = 1'b0;
        wclr[`FLAG_RCV_ABORT] = 1'b0;
        wclr[`FLAG_RCV_UNSUP] = 1'b0;
        wclr[2:1] = 2'b00;
    end

    // Set wins over clear, per flag
    genvar gi;
    generate
        for (gi = 0; gi < `FLAG_COUNT; gi = gi + 1) begin : g_flag
            always @* begin
                flags_d[gi] = ev_vec[gi] | (flags_q[gi] & ~wclr[gi]);
            end
        end
    endgenerate

    // Writable registers and flags
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            io_bot_q    <= `RST_IO_FIELD;
            io_top_q    <= `RST_IO_FIELD;
            io_bot_up_q <= `RST_IO_UPPER;
            io_top_up_q <= `RST_IO_UPPER;
            mem_bot_q   <= `RST_MEM_FIELD;
            mem_top_q   <= `RST_MEM_FIELD;
            flags_q     <= `RST_FLAGS;
            mask_q      <= `RST_MASK;
            perr_en_q   <= 1'b0;
            serr_en_q   <= 1'b0;
        end else begin
            flags_q <= flags_d;
            if (reg_write) begin
                case (reg_addr)
                    `OFS_IO_STATUS: begin
                        io_bot_q <= reg_wdata[`IO_BOT_LSB +: 4];
                        io_top_q <= reg_wdata[`IO_TOP_LSB +: 4];
                    end
                    `OFS_MEM_WINDOW: begin
                        mem_bot_q <= reg_wdata[`MEM_BOT_LSB +: 12];
                        mem_top_q <= reg_wdata[`MEM_TOP_LSB +: 12];
                    end
                    `OFS_IO_UPPER: begin
                        io_bot_up_q <= reg_wdata[15:0];
                        io_top_up_q <= reg_wdata[31:16];
                    end
                    `OFS_IRQ_MASK: begin
                        mask_q <= reg_wdata[`FLAG_LSB +: 8];
                    end
                    `OFS_CONTROL: begin
                        perr_en_q <= reg_wdata[`CTL_PERR_EN_BIT];
                        serr_en_q <= reg_wdata[`CTL_SERR_EN_BIT];
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // Read mux; unmapped addresses read zero
    always @* begin
        rdata_d = 32'h00000000;
        case (reg_addr)
            `OFS_IO_STATUS: begin
                rdata_d[`IO_IND_BOT_LSB +: 4] = `IO_32BIT_IND;
                rdata_d[`IO_BOT_LSB +: 4]     = io_bot_q;
                rdata_d[`IO_IND_TOP_LSB +: 4] = `IO_32BIT_IND;
                rdata_d[`IO_TOP_LSB +: 4]     = io_top_q;
                // Bits 23:16 stay zero: reserved and legacy
                rdata_d[31:24] = {flags_q[7:3], 2'b00, flags_q[0]};
            end
            `OFS_MEM_WINDOW: begin
                rdata_d[`MEM_BOT_LSB +: 12] = mem_bot_q;
                rdata_d[`MEM_TOP_LSB +: 12] = mem_top_q;
            end
            `OFS_IO_UPPER: begin
                rdata_d = {io_top_up_q, io_bot_up_q};
            end
            `OFS_IRQ_MASK: begin
                rdata_d[31:24] = mask_q;
            end
            `OFS_CONTROL: begin
                rdata_d[`CTL_PERR_EN_BIT] = perr_en_q;
                rdata_d[`CTL_SERR_EN_BIT] = serr_en_q;
            end
            default: begin
                rdata_d = 32'h00000000;
            end
        endcase
    end

    // Registered outputs
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata     <= 32'h00000000;
            txn_fwd_valid <= 1'b0;
            txn_forward   <= 1'b0;
            irq           <= 1'b0;
        end else begin
            reg_rdata     <= reg_read ? rdata_d : 32'h00000000;
            txn_fwd_valid <= txn_valid;
            txn_forward   <= txn_valid && (txn_is_io ? io_hit : mem_hit);
            irq           <= |(flags_d & mask_q);
        end
    end

endmodule // bridge_window_regs

`default_nettype wire

// ===== verification/bwr_checker_properties.sv
// Port checks for the bridge window register block
`timescale 1ns/1ns
`default_nettype none
module bwr_checker (
    // Clock and reset
    input wire logic        clk,
    input wire logic        reset_n,
    // Register port
    input wire logic [7:0]  reg_addr,
    input wire logic        reg_read,
    input wire logic [31:0] reg_rdata,
    // Events
    input wire logic        ev_completer_abort_sent,
    input wire logic        ev_completer_abort_rcvd,
    input wire logic        ev_unsupported_rcvd,
    input wire logic        ev_poisoned_rcvd,
    // Decode
    input wire logic        txn_valid,
    input wire logic        txn_fwd_valid,
    input wire logic        txn_forward
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence rd_status;
        reg_read && reg_addr == 8'h1c;
    endsequence
    ind_nibble_a: assert property (rd_status |=>
        reg_rdata[11:8] == 4'h1 && reg_rdata[3:0] == 4'h1) else $error("indicator not one");
    legacy_zero_a: assert property (rd_status |=>
        reg_rdata[26:25] == 2'h0 && reg_rdata[23:16] == 8'h00) else $error("legacy bits set");
    mem_resv_a: assert property (reg_read && reg_addr == 8'h20 |=>
        reg_rdata[19:16] == 4'h0 && reg_rdata[3:0] == 4'h0) else $error("reserved bits set");
    fwd_follow_a: assert property (txn_valid |=> txn_fwd_valid)
        else $error("decode result missing");
    fwd_quiet_a: assert property (!txn_valid |=> !txn_fwd_valid && !txn_forward)
        else $error("decode result without request");
    poison_seen_a: assert property (ev_poisoned_rcvd ##1 rd_status |=> reg_rdata[31])
        else $error("poison flag not set");
    sig_abort_a: assert property (ev_completer_abort_sent ##1 rd_status |=> reg_rdata[27])
        else $error("sent abort flag not set");
    rcv_abort_a: assert property (ev_completer_abort_rcvd ##1 rd_status |=> reg_rdata[28])
        else $error("received abort flag not set");
    unsup_seen_a: assert property (ev_unsupported_rcvd ##1 rd_status |=> reg_rdata[29])
        else $error("unsupported flag not set");
endmodule // bwr_checker
`default_nettype wire

// ===== verification/sec_traffic.sv
// Secondary-side traffic model: registers the request mask onto the event lines one cycle later
`timescale 1ns/1ns
`default_nettype none
module sec_traffic (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       reset_n,
    // Requests and event pulses
    input  wire logic [5:0] fire,
    output var  logic [5:0] ev
);
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ev <= 6'h00;
        end else begin
            ev <= fire;
        end
    end
endmodule // sec_traffic
`default_nettype wire

// ===== verification/testbench.sv
// Self-checking bench for the bridge window registers
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic        clk, reset_n = 1'b0, reg_write = 1'b0, reg_read = 1'b0;
    logic        txn_valid = 1'b0, txn_is_io = 1'b0, txn_fwd_valid, txn_forward, irq;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, txn_addr = 32'h0, reg_rdata;
    logic [5:0]  fire = 6'h00, ev;
    int          errors = 0, comparisons = 0, cycles = 0;
    bridge_window_regs dut_u (.clk, .reset_n, .reg_addr, .reg_wdata, .reg_write, .reg_read,
        .reg_rdata, .ev_parity_error(ev[0]), .ev_completer_abort_sent(ev[1]),
        .ev_completer_abort_rcvd(ev[2]), .ev_unsupported_rcvd(ev[3]),
        .ev_error_msg_sent(ev[4]), .ev_poisoned_rcvd(ev[5]), .txn_valid, .txn_is_io,
        .txn_addr, .txn_fwd_valid, .txn_forward, .irq);
    sec_traffic far_u (.clk, .reset_n, .fire, .ev);
    task chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s exp %h seen %h", n, exp, seen);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_write <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_read <= 1'b0;
        #1 chk("rdata", reg_rdata, exp);
    endtask
    task tx(input logic io, input logic [31:0] a, input logic fwd);
        @(posedge clk);
        txn_valid <= 1'b1;
        txn_is_io <= io;
        txn_addr  <= a;
        @(posedge clk);
        txn_valid <= 1'b0;
        #1 chk("forward", {30'h0, txn_fwd_valid, txn_forward}, {30'h0, 1'b1, fwd});
    endtask
    task pulse(input logic [5:0] m);
        @(posedge clk);
        fire <= m;
        @(posedge clk);
        fire <= 6'h00;
    endtask
    task wrap_up;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            errors++;
            wrap_up();
        end
    end
    initial begin
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        rd(8'h1c, 32'h0000_0101);
        rd(8'h20, 32'h0000_0000);
        rd(8'h50, 32'h0000_0000);
        wr(8'h1c, 32'hffff_ffff);
        rd(8'h1c, 32'h0000_f1f1);
        wr(8'h20, 32'hffff_ffff);
        rd(8'h20, 32'hfff0_fff0);
        $display("test fields done");
        wr(8'h1c, 32'h0000_3020);
        wr(8'h30, 32'h0001_0001);
        wr(8'h20, 32'h1240_1230);
        tx(1'b1, 32'h0001_1fff, 1'b0);
        tx(1'b1, 32'h0001_2000, 1'b1);
        tx(1'b1, 32'h0001_3fff, 1'b1);
        tx(1'b1, 32'h0001_4000, 1'b0);
        tx(1'b1, 32'h0000_2000, 1'b0);
        tx(1'b1, 32'h1230_0000, 1'b0);
        tx(1'b0, 32'h122f_ffff, 1'b0);
        tx(1'b0, 32'h1230_0000, 1'b1);
        tx(1'b0, 32'h124f_ffff, 1'b1);
        tx(1'b0, 32'h1250_0000, 1'b0);
        $display("test decode done");
        wr(8'h40, 32'h8000_0000);
        pulse(6'h3f);
        rd(8'h1c, 32'hb800_3121);
        chk("irq", {31'h0, irq}, 32'h1);
        wr(8'h1c, 32'hff00_3020);
        rd(8'h1c, 32'h3800_3121);
        chk("irq", {31'h0, irq}, 32'h0);
        wr(8'h44, 32'h0000_0003);
        pulse(6'h11);
        rd(8'h1c, 32'h7900_3121);
        wr(8'h1c, 32'h4100_3020);
        rd(8'h1c, 32'h3800_3121);
        fork
            pulse(6'h20);
            begin
                @(posedge clk);
                wr(8'h1c, 32'h8000_3020);
            end
        join
        rd(8'h1c, 32'hb800_3121);
        $display("test flags done");
        wrap_up();
    end
endmodule // testbench
bind bridge_window_regs bwr_checker chk_u (.clk, .reset_n, .reg_addr, .reg_read, .reg_rdata,
    .ev_completer_abort_sent, .ev_completer_abort_rcvd, .ev_unsupported_rcvd,
    .ev_poisoned_rcvd, .txn_valid, .txn_fwd_valid, .txn_forward);
`default_nettype wire
